//--- src/ufe_pkg.sv
/*
 * Package for the UART frame error status block: register map, field
 * positions, reset values and status enumerations.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
 */
package ufe_pkg;

    localparam int UFE_ADDR_W = 12;
    localparam int UFE_DATA_W = 32;

    // Register offsets are word indices: index times four is the byte address
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_CMD = 12'h781;
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_RSP = 12'h782;
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_IRQ_STAT = 12'h790;
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_IRQ_MASK = 12'h791;
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_CTRL = 12'h792;
    localparam logic [UFE_ADDR_W-1:0] UFE_IDX_CNT = 12'h793;

    // Command receive flags
    localparam int UFE_CMD_CRC = 0;
    localparam int UFE_CMD_BYTE = 2;
    localparam int UFE_CMD_SOF = 3;
    localparam int UFE_CMD_TXDIS = 4;
    localparam int UFE_CMD_INIT = 5;

    // Response / transmit flags
    localparam int UFE_RSP_CRC = 0;
    localparam int UFE_RSP_BYTE = 1;
    localparam int UFE_RSP_SOF = 2;
    localparam int UFE_TX_WAIT = 3;
    localparam int UFE_TX_SOF = 4;

    // Control register fields
    localparam int UFE_CTRL_MULTIDROP = 0;
    localparam int UFE_CTRL_TX_EN = 1;

    // Interrupt status layout: low byte command flags, next byte response flags
    localparam int UFE_IRQ_RSP_LSB = 8;
    localparam int UFE_IRQ_W = 16;

    localparam logic [7:0] UFE_FLAGS_RST = 8'h00;
    localparam logic [1:0] UFE_CTRL_RST = 2'h2;
    localparam logic [UFE_IRQ_W-1:0] UFE_MASK_RST = 16'h0000;
    localparam logic [7:0] UFE_CNT_MAX = 8'hFF;
    localparam logic [UFE_DATA_W-1:0] UFE_UNMAPPED = 32'h0000_0000;

    // What the receiver is currently doing with the incoming frame
    typedef enum logic [1:0] {
        UFE_RX_IDLE,
        UFE_RX_FRAME,
        UFE_RX_IGNORE
    } ufe_rx_e;

    // Transmit side progress
    typedef enum logic [1:0] {
        UFE_TX_IDLE,
        UFE_TX_WAITING,
        UFE_TX_SENDING
    } ufe_tx_e;

endpackage

//--- src/ufe_sync.sv
/*
 * Two flip-flop synchroniser for a single level from outside core_clk.
 * Assumes the input is a slow level; the first stage feeds only the second.
 */
`timescale 1ns/100ps
module ufe_sync (
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic async_in, // Level from another domain
    output logic sync_out // Level safe to use in core_clk
);
    logic meta_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- src/ufe_top.sv
/*
 * UART frame error status: sticky command-receive, response-receive and
 * transmit error flags, frame classification pulses, a control register,
 * frame counters and an interrupt, all but the pulses reached over Avalon-MM.
 * Assumes the UART receiver/framer on core_clk reports byte events as
 * one-cycle pulses, and the CLEAR line level arrives from the pin.
 */
// Decided for this implementation: register access over Avalon-MM.
//
// Operation
// - Corrupted non-init byte of a command frame sets the command byte-error flag.
// - After a command byte error, ignore all bytes until CLEAR arrives.
// - Ignored frame gets no error checks and is counted neither valid nor discarded.
// - Command frame failing CRC sets the command CRC-error flag.
// - CLEAR while waiting to respond abandons response, sets wait-terminated bit 3.
// - New command while waiting to respond abandons it, sets wait-terminated flag.
// - CLEAR mid-way through response frame reception sets bit 2.
// - Response frames are received and checked only in multidrop mode.
// - Corrupted non-init response byte sets bit 1, then ignore until CLEAR.
// - Response frame failing CRC sets response CRC-error flag, bit 0.
// - CRC-rejected frames count as discarded, never valid.
//
`timescale 1ns/100ps
module ufe_top (
    input wire logic core_clk, // 200 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [ufe_pkg::UFE_ADDR_W+1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [ufe_pkg::UFE_DATA_W-1:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [ufe_pkg::UFE_DATA_W-1:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic uart_clear_pin, // Raw CLEAR condition level from the line
    input wire logic rx_byte_valid, // Received byte strobe
    input wire logic rx_byte_is_init, // Byte is the frame initialization byte
    input wire logic rx_byte_is_resp, // Init byte announces a response frame
    input wire logic rx_byte_corrupt, // Stop or parity error on this byte
    input wire logic rx_init_bad, // Init byte has bad type or reserved bit
    input wire logic rx_cmd_is_read, // Init byte carries a read command
    input wire logic rx_frame_end, // Last byte of the frame taken
    input wire logic rx_crc_ok, // CRC result, valid with rx_frame_end
    input wire logic tx_pending, // Response is queued for the turn to send
    input wire logic tx_start, // Turn arrived, sending starts
    input wire logic tx_done, // Last response byte sent
    output logic tx_abort, // Pulse: drop the pending response
    output logic frame_valid, // Pulse: frame counted valid
    output logic frame_discard, // Pulse: frame counted discarded
    output logic irq // Level interrupt
);
    import ufe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic clear_lvl, clear_d1_q, clear_rise;
    logic [7:0] cmd_flags_q, rsp_flags_q, valid_cnt_q, discard_cnt_q;
    logic [1:0] ctrl_q;
    logic [UFE_IRQ_W-1:0] irq_stat_q, irq_mask_q, ev_vec;
    logic [7:0] cmd_set, rsp_set;
    ufe_rx_e rx_q;
    ufe_tx_e tx_q;
    logic rx_resp_q;
    logic multidrop, tx_en;
    logic frame_ok, frame_bad;
    logic rd_ack_q;
    logic acc_rd, acc_wr, rd_cmd, rd_rsp, rd_stat;
    logic [UFE_ADDR_W-1:0] idx;

    ufe_sync u_clear_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(uart_clear_pin),
        .sync_out(clear_lvl)
    );

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clear_d1_q <= 1'b0;
        end else begin
            clear_d1_q <= clear_lvl;
        end
    end
    assign clear_rise = clear_lvl & ~clear_d1_q;

    assign multidrop = ctrl_q[UFE_CTRL_MULTIDROP];
    assign tx_en = ctrl_q[UFE_CTRL_TX_EN];

    ////////////////////////////////////////////////////////////////////////
    // Receive frame tracking
    logic new_init, accept_init, init_fail, byte_fail;
    assign new_init = rx_byte_valid & rx_byte_is_init & (rx_q != UFE_RX_IGNORE);
    // Response frames are dropped silently outside multidrop
    assign accept_init = new_init & (~rx_byte_is_resp | multidrop);
    assign init_fail = accept_init & ~rx_byte_is_resp & (rx_byte_corrupt | rx_init_bad);
    assign byte_fail = rx_byte_valid & ~rx_byte_is_init & rx_byte_corrupt & (rx_q == UFE_RX_FRAME);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rx_q <= UFE_RX_IDLE;
            rx_resp_q <= 1'b0;
        end else begin
            case (rx_q)
                UFE_RX_IDLE: begin
                    if (init_fail) begin
                        rx_q <= UFE_RX_IGNORE;
                    end else if (accept_init && !rx_frame_end) begin
                        rx_q <= UFE_RX_FRAME;
                        rx_resp_q <= rx_byte_is_resp;
                    end
                end
                UFE_RX_FRAME: begin
                    if (clear_rise) begin
                        rx_q <= UFE_RX_IDLE;
                    end else if (byte_fail) begin
                        rx_q <= UFE_RX_IGNORE;
                    end else if (rx_frame_end) begin
                        rx_q <= UFE_RX_IDLE;
                    end
                end
                UFE_RX_IGNORE: begin
                    // Only CLEAR leaves; every byte meanwhile is dropped
                    if (clear_rise) begin
                        rx_q <= UFE_RX_IDLE;
                    end
                end
                default: begin
                    rx_q <= UFE_RX_IDLE;
                end
            endcase
        end
    end

    // Counting only from a tracked frame, never from an ignored one
    assign frame_ok = (rx_q == UFE_RX_FRAME) & rx_frame_end & ~byte_fail & ~clear_rise & rx_crc_ok;
    assign frame_bad = (rx_q == UFE_RX_FRAME) & rx_frame_end & ~byte_fail & ~clear_rise & ~rx_crc_ok;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            frame_valid <= 1'b0;
            frame_discard <= 1'b0;
        end else begin
            frame_valid <= frame_ok;
            frame_discard <= frame_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit tracking
    logic wait_abort;
    assign wait_abort = (tx_q == UFE_TX_WAITING) & (clear_rise | (accept_init & ~rx_byte_is_resp));

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tx_q <= UFE_TX_IDLE;
            tx_abort <= 1'b0;
        end else begin
            tx_abort <= wait_abort;
            case (tx_q)
                UFE_TX_IDLE: begin
                    if (tx_start) begin
                        tx_q <= UFE_TX_SENDING;
                    end else if (tx_pending && !tx_abort) begin // Queue drops an abandoned response a cycle late
                        tx_q <= UFE_TX_WAITING;
                    end
                end
                UFE_TX_WAITING: begin
                    if (wait_abort) begin
                        tx_q <= UFE_TX_IDLE;
                    end else if (tx_start) begin
                        tx_q <= UFE_TX_SENDING;
                    end
                end
                UFE_TX_SENDING: begin
                    if (tx_done || clear_rise) begin
                        tx_q <= UFE_TX_IDLE;
                    end
                end
                default: begin
                    tx_q <= UFE_TX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag set terms
    logic in_cmd, in_rsp;
    assign in_cmd = (rx_q == UFE_RX_FRAME) & ~rx_resp_q;
    assign in_rsp = (rx_q == UFE_RX_FRAME) & rx_resp_q;

    always_comb begin
        cmd_set = UFE_FLAGS_RST;
        rsp_set = UFE_FLAGS_RST;
        cmd_set[UFE_CMD_BYTE] = in_cmd & byte_fail & ~clear_rise;
        cmd_set[UFE_CMD_CRC] = in_cmd & frame_bad;
        cmd_set[UFE_CMD_SOF] = in_cmd & clear_rise;
        cmd_set[UFE_CMD_INIT] = init_fail;
        cmd_set[UFE_CMD_TXDIS] = accept_init & ~rx_byte_is_resp & ~init_fail & rx_cmd_is_read & ~tx_en;
        rsp_set[UFE_RSP_BYTE] = in_rsp & byte_fail & ~clear_rise;
        rsp_set[UFE_RSP_CRC] = in_rsp & frame_bad;
        rsp_set[UFE_RSP_SOF] = in_rsp & clear_rise;
        rsp_set[UFE_TX_WAIT] = wait_abort;
        rsp_set[UFE_TX_SOF] = (tx_q == UFE_TX_SENDING) & clear_rise & ~tx_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait state on reads so data comes from flops
    assign idx = avs_address[UFE_ADDR_W+1:2];
    assign acc_rd = avs_read & rd_ack_q;
    assign acc_wr = avs_write;
    assign avs_waitrequest = avs_read & ~rd_ack_q;
    assign rd_cmd = acc_rd & (idx == UFE_IDX_CMD);
    assign rd_rsp = acc_rd & (idx == UFE_IDX_RSP);
    assign rd_stat = acc_rd & (idx == UFE_IDX_IRQ_STAT);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= avs_read & ~rd_ack_q;
        end
    end

    // Read-to-clear removes only the bits returned, so a set at the latch edge is not lost;
    // a set in the same cycle as the clearing read wins
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cmd_flags_q <= UFE_FLAGS_RST;
            rsp_flags_q <= UFE_FLAGS_RST;
        end else begin
            cmd_flags_q <= (rd_cmd ? cmd_flags_q & ~avs_readdata[7:0] : cmd_flags_q) | cmd_set;
            rsp_flags_q <= (rd_rsp ? rsp_flags_q & ~avs_readdata[7:0] : rsp_flags_q) | rsp_set;
        end
    end

    assign ev_vec = {rsp_set, cmd_set};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_stat_q <= UFE_MASK_RST;
        end else begin
            irq_stat_q <= (rd_stat ? irq_stat_q & ~avs_readdata[UFE_IRQ_W-1:0] : irq_stat_q) | ev_vec;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_mask_q <= UFE_MASK_RST;
            ctrl_q <= UFE_CTRL_RST;
        end else if (acc_wr) begin
            if (idx == UFE_IDX_IRQ_MASK) begin
                if (avs_byteenable[0]) begin
                    irq_mask_q[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    irq_mask_q[15:8] <= avs_writedata[15:8];
                end
            end else if (idx == UFE_IDX_CTRL) begin
                if (avs_byteenable[0]) begin
                    ctrl_q <= avs_writedata[1:0];
                end
            end
        end
    end

    // Saturating counters of classified frames, cleared on read
    logic rd_cnt;
    assign rd_cnt = acc_rd & (idx == UFE_IDX_CNT);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            valid_cnt_q <= UFE_FLAGS_RST;
            discard_cnt_q <= UFE_FLAGS_RST;
        end else if (rd_cnt) begin
            // Frames counted after the latch edge stay for the next read
            valid_cnt_q <= valid_cnt_q - avs_readdata[7:0] + {7'h00, frame_valid};
            discard_cnt_q <= discard_cnt_q - avs_readdata[15:8] + {7'h00, frame_discard};
        end else begin
            if (frame_valid && valid_cnt_q != UFE_CNT_MAX) begin
                valid_cnt_q <= valid_cnt_q + 8'h01;
            end
            if (frame_discard && discard_cnt_q != UFE_CNT_MAX) begin
                discard_cnt_q <= discard_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            avs_readdata <= UFE_UNMAPPED;
        end else if (avs_read && !rd_ack_q) begin
            if (idx == UFE_IDX_CMD) begin
                avs_readdata <= {24'h000000, cmd_flags_q};
            end else if (idx == UFE_IDX_RSP) begin
                avs_readdata <= {24'h000000, rsp_flags_q};
            end else if (idx == UFE_IDX_IRQ_STAT) begin
                avs_readdata <= {16'h0000, irq_stat_q};
            end else if (idx == UFE_IDX_IRQ_MASK) begin
                avs_readdata <= {16'h0000, irq_mask_q};
            end else if (idx == UFE_IDX_CTRL) begin
                avs_readdata <= {30'h00000000, ctrl_q};
            end else if (idx == UFE_IDX_CNT) begin
                avs_readdata <= {16'h0000, discard_cnt_q, valid_cnt_q};
            end else begin
                avs_readdata <= UFE_UNMAPPED;
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

endmodule

//--- dv/ufe_props.sv
/* Port checker for ufe_top: bus stall, frame counting and abort relations.
   Assumes it is bound to ufe_top and runs on core_clk only. */
`timescale 1ns/100ps
module ufe_props (
    input wire logic core_clk, // Clock
    input wire logic reset_n, // Reset, low
    input wire logic avs_read, // Bus read
    input wire logic avs_write, // Bus write
    input wire logic [ufe_pkg::UFE_DATA_W-1:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic rx_byte_valid, // Byte strobe
    input wire logic rx_byte_corrupt, // Bad byte
    input wire logic rx_frame_end, // Frame end
    input wire logic rx_crc_ok, // CRC good
    input wire logic tx_pending, // Response queued
    input wire logic tx_abort, // Abort pulse
    input wire logic frame_valid, // Valid pulse
    input wire logic frame_discard, // Discard pulse
    input wire logic irq // Interrupt
);
    import ufe_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    property p_rd_wait;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read stall is not one cycle");
    property p_wr_go;
        avs_write |-> !avs_waitrequest;
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("write stalled");
    property p_rd_hold;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_one_kind;
        !(frame_valid && frame_discard);
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("frame counted twice");
    property p_valid;
        frame_valid |-> $past(rx_frame_end) && $past(rx_crc_ok);
    endproperty
    a_valid: assert property (p_valid) else $error("valid count without good frame end");
    property p_discard;
        frame_discard |-> $past(rx_frame_end) && !$past(rx_crc_ok);
    endproperty
    a_discard: assert property (p_discard) else $error("discard without failed frame end");
    // Two cycles cover an end in the same byte and the next one; CLEAR needs three
    property p_ignore;
        rx_byte_valid && rx_byte_corrupt |=> (!frame_valid && !frame_discard) [*2];
    endproperty
    a_ignore: assert property (p_ignore) else $error("frame counted after a bad byte");
    property p_abort;
        tx_abort |-> $past(tx_pending);
    endproperty
    a_abort: assert property (p_abort) else $error("abort with no pending response");
    c_valid: cover property (frame_valid);
    c_discard: cover property (frame_discard);
    c_abort: cover property (tx_abort);
    c_irq: cover property ($rose(irq));
endmodule

//--- dv/ufe_host_model.sv
/* Host-side framer model: byte events, CLEAR level and the transmit turn.
   Assumes the bench calls its tasks one at a time, right after a clock edge. */
`timescale 1ns/100ps
module ufe_host_model (
    input wire logic core_clk, // Clock
    input wire logic tx_abort, // Drop request
    output logic uart_clear_pin, // CLEAR level
    output logic rx_byte_valid, // Byte strobe
    output logic rx_byte_is_init, // Init byte
    output logic rx_byte_is_resp, // Response frame
    output logic rx_byte_corrupt, // Bad byte
    output logic rx_init_bad, // Bad init
    output logic rx_cmd_is_read, // Read command
    output logic rx_frame_end, // Last byte
    output logic rx_crc_ok, // CRC good
    output logic tx_pending, // Response queued
    output logic tx_start, // Turn arrived
    output logic tx_done // Sent
);
    initial begin
        {uart_clear_pin, rx_byte_valid, rx_frame_end, tx_pending, tx_start, tx_done} = '0;
        {rx_byte_is_init, rx_byte_is_resp, rx_byte_corrupt, rx_init_bad, rx_cmd_is_read, rx_crc_ok} = '0;
    end
    // An abandoned response is withdrawn from the queue
    always @(posedge core_clk) begin
        if (tx_abort === 1'b1) begin
            tx_pending <= 1'b0;
        end
    end
    // q: init, resp, corrupt, bad init, read, crc ok
    task automatic byte_ev(input logic [5:0] q, input logic last);
        @(posedge core_clk);
        rx_byte_valid <= 1'b1;
        rx_frame_end <= last;
        {rx_byte_is_init, rx_byte_is_resp, rx_byte_corrupt, rx_init_bad, rx_cmd_is_read, rx_crc_ok} <= q;
        @(posedge core_clk);
        rx_byte_valid <= 1'b0;
        rx_frame_end <= 1'b0;
        // Stale qualifiers must not look valid, so they flip
        {rx_byte_is_init, rx_byte_is_resp, rx_byte_corrupt, rx_init_bad, rx_cmd_is_read, rx_crc_ok} <= ~q;
    endtask
    task automatic frame(input logic resp, input logic rd, input logic crc, input int mid);
        byte_ev({1'b1, resp, 2'b00, rd, 1'b1}, 1'b0);
        repeat (mid) byte_ev(6'b000001, 1'b0);
        byte_ev({5'b00000, crc}, 1'b1);
    endtask
    task automatic clear();
        @(posedge core_clk);
        uart_clear_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        uart_clear_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // v: pending, start, done
    task automatic tx_ev(input logic [2:0] v);
        @(posedge core_clk);
        {tx_pending, tx_start, tx_done} <= v;
        @(posedge core_clk);
        {tx_start, tx_done} <= 2'b00;
    endtask
endmodule

//--- dv/ufe_top_tb.sv
/* Self-checking bench for ufe_top: Avalon-MM master, host model, scoreboard.
   Assumes the host model drives every UART-side input. */
`timescale 1ns/100ps
module ufe_top_tb;
    import ufe_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [UFE_ADDR_W+1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [UFE_DATA_W-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [UFE_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, uart_clear_pin, rx_byte_valid, rx_byte_is_init, rx_byte_is_resp, rx_byte_corrupt;
    logic rx_init_bad, rx_cmd_is_read, rx_frame_end, rx_crc_ok, tx_pending, tx_start, tx_done;
    logic tx_abort, frame_valid, frame_discard, irq;
    int errors = 0;
    int comparisons = 0;
    int n_valid = 0, n_discard = 0, n_abort = 0;
    logic [31:0] exp_q[$];
    always #2.5 core_clk = ~core_clk;
    ufe_top dut_u (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .uart_clear_pin, .rx_byte_valid, .rx_byte_is_init, .rx_byte_is_resp,
        .rx_byte_corrupt, .rx_init_bad, .rx_cmd_is_read, .rx_frame_end, .rx_crc_ok, .tx_pending, .tx_start,
        .tx_done, .tx_abort, .frame_valid, .frame_discard, .irq);
    ufe_host_model host_u (.core_clk, .tx_abort, .uart_clear_pin, .rx_byte_valid, .rx_byte_is_init,
        .rx_byte_is_resp, .rx_byte_corrupt, .rx_init_bad, .rx_cmd_is_read, .rx_frame_end, .rx_crc_ok,
        .tx_pending, .tx_start, .tx_done);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Read when rd: data is the expected word, checked by the monitor at acceptance
    task automatic bus(input logic rd, input logic [11:0] idx, input logic [31:0] data);
        int n;
        n = 0;
        if (rd) begin
            exp_q.push_back(data);
        end
        avs_address <= {idx, 2'b00};
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= data;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) begin
            errors++;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    // Sampled mid-cycle so the flag update of the last edge has landed
    task automatic irq_is(input logic e);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (reset_n && avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                errors++;
            end else begin
                chk(avs_readdata, exp_q.pop_front());
            end
        end
        n_valid += (frame_valid === 1'b1);
        n_discard += (frame_discard === 1'b1);
        n_abort += (tx_abort === 1'b1);
    end
    initial begin
        #50000;
        errors++;
        stop_test();
    end
    initial begin
        int mid;
        void'($urandom(32'h5C03));
        mid = $urandom_range(3, 0);
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(1'b1, UFE_IDX_CMD, 32'h0);
        bus(1'b1, UFE_IDX_RSP, 32'h0);
        bus(1'b1, UFE_IDX_CTRL, 32'h2);
        bus(1'b1, UFE_IDX_IRQ_MASK, 32'h0);
        bus(1'b1, 12'h7FF, 32'h0);
        bus(1'b0, UFE_IDX_CMD, 32'hFF);
        bus(1'b1, UFE_IDX_CMD, 32'h0);
        bus(1'b0, UFE_IDX_IRQ_MASK, 32'h1 << UFE_CMD_CRC);
        host_u.frame(1'b0, 1'b0, 1'b1, mid);
        host_u.frame(1'b0, 1'b0, 1'b0, mid);
        irq_is(1'b1);
        bus(1'b1, UFE_IDX_CMD, 32'h1 << UFE_CMD_CRC);
        chk(n_valid, 1);
        chk(n_discard, 1);
        bus(1'b1, UFE_IDX_IRQ_STAT, 32'h1);
        irq_is(1'b0);
        bus(1'b1, UFE_IDX_CNT, 32'h0101);
        bus(1'b0, UFE_IDX_IRQ_MASK, 32'h0);
        host_u.byte_ev(6'b100001, 1'b0);
        host_u.byte_ev(6'b001001, 1'b0);
        host_u.byte_ev(6'b001001, 1'b0);
        host_u.byte_ev(6'b000000, 1'b1);
        bus(1'b1, UFE_IDX_CMD, 32'h1 << UFE_CMD_BYTE);
        chk(n_discard, 1);
        host_u.clear();
        bus(1'b1, UFE_IDX_CMD, 32'h0);
        for (int i = 0; i < 2; i++) begin
            host_u.byte_ev({1'b1, 1'b0, i == 0, i == 1, 2'b01}, 1'b0);
            host_u.byte_ev(6'b001001, 1'b1);
            bus(1'b1, UFE_IDX_CMD, 32'h1 << UFE_CMD_INIT);
            host_u.clear();
        end
        host_u.byte_ev(6'b100001, 1'b0);
        host_u.byte_ev(6'b000001, 1'b0);
        host_u.clear();
        bus(1'b1, UFE_IDX_CMD, 32'h1 << UFE_CMD_SOF);
        bus(1'b1, UFE_IDX_CNT, 32'h0);
        bus(1'b0, UFE_IDX_CTRL, 32'h0);
        host_u.frame(1'b0, 1'b1, 1'b1, 0);
        bus(1'b1, UFE_IDX_CMD, 32'h1 << UFE_CMD_TXDIS);
        bus(1'b0, UFE_IDX_CTRL, 32'h1 << UFE_CTRL_TX_EN);
        host_u.frame(1'b1, 1'b0, 1'b0, mid);
        bus(1'b1, UFE_IDX_RSP, 32'h0);
        chk(n_discard, 1);
        bus(1'b0, UFE_IDX_CTRL, 32'h3);
        host_u.frame(1'b1, 1'b0, 1'b0, mid);
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_RSP_CRC);
        chk(n_discard, 2);
        host_u.byte_ev(6'b110001, 1'b0);
        host_u.byte_ev(6'b001001, 1'b0);
        host_u.byte_ev(6'b000000, 1'b1);
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_RSP_BYTE);
        chk(n_discard, 2);
        host_u.clear();
        host_u.byte_ev(6'b110001, 1'b0);
        host_u.clear();
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_RSP_SOF);
        host_u.tx_ev(3'b100);
        host_u.clear();
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_TX_WAIT);
        chk(n_abort, 1);
        host_u.clear();
        bus(1'b1, UFE_IDX_RSP, 32'h0);
        chk(n_abort, 1);
        host_u.tx_ev(3'b100);
        host_u.frame(1'b0, 1'b0, 1'b1, 0);
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_TX_WAIT);
        chk(n_abort, 2);
        host_u.tx_ev(3'b100);
        host_u.tx_ev(3'b010);
        host_u.clear();
        bus(1'b1, UFE_IDX_RSP, 32'h1 << UFE_TX_SOF);
        host_u.tx_ev(3'b001);
        irq_is(1'b0);
        stop_test();
    end
endmodule

bind ufe_top ufe_props props_u (.core_clk, .reset_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .rx_byte_valid, .rx_byte_corrupt, .rx_frame_end, .rx_crc_ok, .tx_pending, .tx_abort, .frame_valid,
    .frame_discard, .irq);
